// file: rtl/soag_addr_gen.sv
/*
 Segmented operand address generator: picks the segment for a memory
 reference, forms the 16-bit offset and the 20-bit physical address, and
 exposes the operand format helpers the datapath relies on.
 Assumes requests arrive synchronous to clk from the decoder, one per cycle.
*/
// Operation
// - Unnamed data moves use data segment.
// - All fetches use code segment.
// - Stack ops and base pointer use stack.
// - String destination index uses extra segment.
// - Override prefix replaces implied segment; not applied here to fetches, stack ops or string destination.
// - Each segment spans a 64K window.
// - Offset sums displacement, base and index.
// - Offset carry out of bit 15 dropped.
// - Byte displacement sign-extended to sixteen bits.
// - Direct mode offset is displacement only.
// - Register indirect offset is one register.
// - Based mode adds displacement to base.
// - Indexed mode adds displacement to index.
// - Based indexed sums base and index.
// - Based indexed with displacement sums all three.
// - Signed operands are two's complement.
// - Packed decimal holds one digit per nibble.
// - Double word in memory pair or accumulators.
// - Strings span one byte to 64K.
// - Pointers are offset or segment plus offset.
`include "soag_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module soag_addr_gen
   import soag_pkg::*;
(
   // Clock and reset
   input  wire  logic        clk,
   input  wire  logic        rst,
   // Register file views
   input  wire  soag_segs_t  segs,
   input  wire  soag_gprs_t  gprs,
   // Decoder request
   input  wire  logic        req_valid,
   input  wire  soag_req_t   req,
   // Address result
   output logic              resp_valid,
   output soag_resp_t        resp,
   // Operand format helpers
   input  wire  logic [15:0] op_a,
   input  wire  logic [15:0] op_b,
   input  wire  logic        op_byte,
   output logic [16:0]       op_signed_sum,
   output logic [7:0]        bcd_packed,
   input  wire  logic [3:0]  bcd_hi_digit,
   input  wire  logic [3:0]  bcd_lo_digit,
   output logic [31:0]       dword_value,
   output logic [31:0]       far_pointer,
   input  wire  logic [16:0] str_len,
   output logic              str_len_ok
);

   soag_seg_t   next_seg_sel;
   logic [15:0] next_seg_val;
   logic [15:0] disp_ext;
   logic [15:0] base_val;
   logic [15:0] index_val;
   logic [15:0] next_eff_addr;
   logic [19:0] next_phys_addr;
   logic [16:0] byte_a;
   logic [16:0] byte_b;
   logic        bp_in_ofs;

   // Whether the offset is built on the base pointer. Register indirect names its
   // register through the low displacement bits, so use_bp alone would mislead there.
   always_comb begin
      unique case (req.mode)
         SOAG_AM_REG_IND:       bp_in_ofs = (req.disp[1:0] == 2'h3);
         SOAG_AM_BASED,
         SOAG_AM_BASE_IDX,
         SOAG_AM_BASE_IDX_DISP: bp_in_ofs = req.use_bp;
         default:               bp_in_ofs = 1'b0;
      endcase
   end

   // Implied segment from reference kind, then the prefix wins for data and string source references.
   always_comb begin
      unique case (req.ref_kind)
         SOAG_REF_FETCH:   next_seg_sel = SOAG_SEG_CODE;
         SOAG_REF_STACK:   next_seg_sel = SOAG_SEG_STACK;
         SOAG_REF_STR_DST: next_seg_sel = req.use_di ? SOAG_SEG_EXTRA
                                                     : SOAG_SEG_DATA;
         default:          next_seg_sel = bp_in_ofs ? SOAG_SEG_STACK
                                                    : SOAG_SEG_DATA;
      endcase
      // Fetches, stack ops and the string destination cannot be redirected by a prefix.
      if (req.ovr_valid && req.ref_kind != SOAG_REF_FETCH &&
          req.ref_kind != SOAG_REF_STR_DST && req.ref_kind != SOAG_REF_STACK) begin
         next_seg_sel = req.ovr_seg;
      end
   end

   always_comb begin
      unique case (next_seg_sel)
         SOAG_SEG_DATA:  next_seg_val = segs.data_segment_reg;
         SOAG_SEG_CODE:  next_seg_val = segs.code_segment_reg;
         SOAG_SEG_STACK: next_seg_val = segs.stack_segment_reg;
         SOAG_SEG_EXTRA: next_seg_val = segs.extra_segment_reg;
      endcase
   end

   // Offset components; the 16-bit sum wraps within the 64K window.
   always_comb begin
      disp_ext  = req.disp_wide ? req.disp
                : {{8{req.disp[`SOAG_DISP8_SIGN]}}, req.disp[7:0]};
      base_val  = req.use_bp ? gprs.base_pointer_reg : gprs.general_base_reg;
      index_val = req.use_di ? gprs.dest_index_reg : gprs.src_index_reg;
      unique case (req.mode)
         SOAG_AM_DIRECT:        next_eff_addr = disp_ext;
         SOAG_AM_REG_IND:       next_eff_addr = (req.disp[1:0] == 2'h0) ? gprs.src_index_reg
                                              : (req.disp[1:0] == 2'h1) ? gprs.dest_index_reg
                                              : (req.disp[1:0] == 2'h2) ? gprs.general_base_reg
                                              : gprs.base_pointer_reg;
         SOAG_AM_BASED:         next_eff_addr = 16'(base_val + disp_ext);
         SOAG_AM_INDEXED:       next_eff_addr = 16'(index_val + disp_ext);
         SOAG_AM_BASE_IDX:      next_eff_addr = 16'(base_val + index_val);
         SOAG_AM_BASE_IDX_DISP: next_eff_addr = 16'(base_val + index_val + disp_ext);
         default:               next_eff_addr = disp_ext;
      endcase
      if (req.ref_kind == SOAG_REF_FETCH) begin
         next_eff_addr = req.fetch_ofs;
      end else if (req.ref_kind == SOAG_REF_STACK) begin
         next_eff_addr = req.stack_ofs;
      end
      next_phys_addr = 20'({next_seg_val, {`SOAG_SEG_SHIFT{1'b0}}} + {4'h0, next_eff_addr});
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         resp_valid <= 1'b0;
         resp       <= '{phys_addr: `SOAG_ADDR_RST, eff_addr: `SOAG_OFS_RST,
                         seg_sel: SOAG_SEG_DATA, seg_val: `SOAG_OFS_RST};
      end else begin
         resp_valid <= req_valid;
         if (req_valid) begin
            resp <= '{phys_addr: next_phys_addr, eff_addr: next_eff_addr,
                      seg_sel: next_seg_sel, seg_val: next_seg_val};
         end
      end
   end

   // Operand format helpers, registered so the datapath sees stable values.
   always_comb begin
      byte_a = op_byte ? {{9{op_a[7]}}, op_a[7:0]} : {op_a[15], op_a};
      byte_b = op_byte ? {{9{op_b[7]}}, op_b[7:0]} : {op_b[15], op_b};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         op_signed_sum <= 17'h00000;
         bcd_packed    <= 8'h00;
         dword_value   <= 32'h00000000;
         far_pointer   <= 32'h00000000;
         str_len_ok    <= 1'b0;
      end else begin
         op_signed_sum <= 17'(byte_a + byte_b);
         bcd_packed    <= {bcd_hi_digit, bcd_lo_digit};
         dword_value   <= {gprs.high_accum_reg, gprs.low_accum_reg};
         far_pointer   <= {next_seg_val, next_eff_addr};
         str_len_ok    <= (str_len != 17'h00000) && (str_len <= `SOAG_STR_MAX);
      end
   end

   // Segment choice, checked one cycle after each taken request.
   fetch_seg_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.ref_kind == SOAG_REF_FETCH |=> resp.seg_sel == SOAG_SEG_CODE)
      else $error("fetch not in code segment");

   fetch_ofs_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.ref_kind == SOAG_REF_FETCH |=> resp.eff_addr == $past(req.fetch_ofs))
      else $error("fetch offset not taken from the fetch pointer");

   stack_seg_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.ref_kind == SOAG_REF_STACK |=> resp.seg_sel == SOAG_SEG_STACK)
      else $error("stack op not in stack segment");

   stack_ofs_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.ref_kind == SOAG_REF_STACK |=> resp.eff_addr == $past(req.stack_ofs))
      else $error("stack offset not taken from the stack pointer");

   reg_ind_bp_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && !req.ovr_valid && req.ref_kind == SOAG_REF_DATA
      && req.mode == SOAG_AM_REG_IND && req.disp[1:0] == 2'h3
      |=> resp.seg_sel == SOAG_SEG_STACK)
      else $error("base pointer indirect not in stack segment");

   based_bp_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && !req.ovr_valid && req.ref_kind == SOAG_REF_DATA && req.use_bp
      && (req.mode == SOAG_AM_BASED || req.mode == SOAG_AM_BASE_IDX
          || req.mode == SOAG_AM_BASE_IDX_DISP)
      |=> resp.seg_sel == SOAG_SEG_STACK)
      else $error("base pointer based reference not in stack segment");

   str_dst_seg_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.ref_kind == SOAG_REF_STR_DST && req.use_di
      |=> resp.seg_sel == SOAG_SEG_EXTRA)
      else $error("string destination not in extra segment");

   override_seg_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.ovr_valid
      && (req.ref_kind == SOAG_REF_DATA || req.ref_kind == SOAG_REF_STR_SRC)
      |=> resp.seg_sel == $past(req.ovr_seg))
      else $error("override prefix ignored");

   data_default_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && !req.ovr_valid && req.ref_kind == SOAG_REF_DATA && !req.use_bp
      && req.mode != SOAG_AM_REG_IND |=> resp.seg_sel == SOAG_SEG_DATA)
      else $error("data reference not in data segment");

   // Segment value handed on must be the register picked at request time.
   seg_data_val_a: assert property (@(posedge clk) disable iff (rst)
      resp_valid && resp.seg_sel == SOAG_SEG_DATA
      |-> resp.seg_val == $past(segs.data_segment_reg))
      else $error("data segment value wrong");

   seg_code_val_a: assert property (@(posedge clk) disable iff (rst)
      resp_valid && resp.seg_sel == SOAG_SEG_CODE
      |-> resp.seg_val == $past(segs.code_segment_reg))
      else $error("code segment value wrong");

   seg_stack_val_a: assert property (@(posedge clk) disable iff (rst)
      resp_valid && resp.seg_sel == SOAG_SEG_STACK
      |-> resp.seg_val == $past(segs.stack_segment_reg))
      else $error("stack segment value wrong");

   seg_extra_val_a: assert property (@(posedge clk) disable iff (rst)
      resp_valid && resp.seg_sel == SOAG_SEG_EXTRA
      |-> resp.seg_val == $past(segs.extra_segment_reg))
      else $error("extra segment value wrong");

   // Offsets, built from the raw inputs; the physical address and far pointer checks use the response fields.
   direct_ofs_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.mode == SOAG_AM_DIRECT && req.ref_kind == SOAG_REF_DATA
      && !req.disp_wide
      |=> resp.eff_addr == {{8{$past(req.disp[7])}}, $past(req.disp[7:0])})
      else $error("byte displacement not sign extended");

   direct_wide_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.mode == SOAG_AM_DIRECT && req.ref_kind == SOAG_REF_DATA
      && req.disp_wide |=> resp.eff_addr == $past(req.disp))
      else $error("direct offset not the displacement");

   reg_ind_si_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.mode == SOAG_AM_REG_IND && req.disp[1:0] == 2'h0
      && req.ref_kind != SOAG_REF_FETCH && req.ref_kind != SOAG_REF_STACK
      |=> resp.eff_addr == $past(gprs.src_index_reg))
      else $error("indirect offset not the source index");

   reg_ind_bpo_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.mode == SOAG_AM_REG_IND && req.disp[1:0] == 2'h3
      && req.ref_kind != SOAG_REF_FETCH && req.ref_kind != SOAG_REF_STACK
      |=> resp.eff_addr == $past(gprs.base_pointer_reg))
      else $error("indirect offset not the base pointer");

   based_ofs_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.mode == SOAG_AM_BASED && req.ref_kind == SOAG_REF_DATA
      && !req.use_bp && req.disp_wide
      |=> resp.eff_addr == 16'($past(gprs.general_base_reg) + $past(req.disp)))
      else $error("based offset wrong");

   indexed_ofs_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.mode == SOAG_AM_INDEXED && req.ref_kind == SOAG_REF_DATA
      && req.use_di && !req.disp_wide
      |=> resp.eff_addr == 16'($past(gprs.dest_index_reg)
                               + {{8{$past(req.disp[7])}}, $past(req.disp[7:0])}))
      else $error("indexed offset wrong");

   base_idx_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.mode == SOAG_AM_BASE_IDX && req.ref_kind == SOAG_REF_DATA
      && req.use_bp && !req.use_di
      |=> resp.eff_addr == 16'($past(gprs.base_pointer_reg) + $past(gprs.src_index_reg)))
      else $error("based indexed offset wrong");

   full_sum_a: assert property (@(posedge clk) disable iff (rst)
      req_valid && req.mode == SOAG_AM_BASE_IDX_DISP && req.ref_kind == SOAG_REF_DATA
      && !req.use_bp && req.use_di && !req.disp_wide
      |=> resp.eff_addr == 16'($past(gprs.general_base_reg) + $past(gprs.dest_index_reg)
                               + {{8{$past(req.disp[7])}}, $past(req.disp[7:0])}))
      else $error("three part offset wrong");

   phys_form_a: assert property (@(posedge clk) disable iff (rst)
      resp_valid |-> resp.phys_addr
      == 20'({resp.seg_val, 4'h0} + {4'h0, resp.eff_addr}))
      else $error("physical address not segment times 16 plus offset");

   far_ptr_a: assert property (@(posedge clk) disable iff (rst)
      req_valid |=> far_pointer == {resp.seg_val, resp.eff_addr})
      else $error("far pointer not segment then offset");

   // Operand format helpers.
   signed_sum_a: assert property (@(posedge clk) disable iff (rst)
      !op_byte |=> op_signed_sum
      == 17'({$past(op_a[15]), $past(op_a)} + {$past(op_b[15]), $past(op_b)}))
      else $error("word sum not two's complement");

   dword_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> dword_value == {$past(gprs.high_accum_reg), $past(gprs.low_accum_reg)})
      else $error("double word halves out of order");

   str_len_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> str_len_ok
      == ($past(str_len) != 17'h00000 && $past(str_len) <= `SOAG_STR_MAX))
      else $error("string length range wrong");

   bcd_pack_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> bcd_packed[7:4] == $past(bcd_hi_digit)
      && bcd_packed[3:0] == $past(bcd_lo_digit))
      else $error("packed digit order wrong");

endmodule : soag_addr_gen
`default_nettype wire

// file: rtl/soag_defs.svh
/*
 Constants for the segmented operand address generator.
 Assumes inclusion by bare name from files under rtl/.
*/
`ifndef SOAG_DEFS_SVH
`define SOAG_DEFS_SVH
`define SOAG_OFS_W        16
`define SOAG_PHYS_W       20
`define SOAG_SEG_SHIFT    4
`define SOAG_NIB_W        4
`define SOAG_DISP8_SIGN   7
`define SOAG_ADDR_RST     20'h00000
`define SOAG_OFS_RST      16'h0000
`define SOAG_STR_MAX      17'h10000
`endif

// file: rtl/soag_pkg.sv
/*
 Types for the segmented operand address generator.
 Assumes soag_defs.svh is on the include path.
*/
`include "soag_defs.svh"
package soag_pkg;
   typedef enum logic [1:0] {SOAG_SEG_DATA, SOAG_SEG_CODE, SOAG_SEG_STACK,
                             SOAG_SEG_EXTRA} soag_seg_t;
   typedef enum logic [2:0] {SOAG_REF_DATA, SOAG_REF_FETCH, SOAG_REF_STACK,
                             SOAG_REF_STR_SRC, SOAG_REF_STR_DST} soag_ref_t;
   typedef enum logic [2:0] {SOAG_AM_DIRECT, SOAG_AM_REG_IND, SOAG_AM_BASED,
                             SOAG_AM_INDEXED, SOAG_AM_BASE_IDX,
                             SOAG_AM_BASE_IDX_DISP} soag_mode_t;
   typedef struct packed {
      logic [15:0] data_segment_reg;
      logic [15:0] code_segment_reg;
      logic [15:0] stack_segment_reg;
      logic [15:0] extra_segment_reg;
   } soag_segs_t;
   typedef struct packed {
      logic [15:0] general_base_reg;
      logic [15:0] base_pointer_reg;
      logic [15:0] src_index_reg;
      logic [15:0] dest_index_reg;
      logic [15:0] high_accum_reg;
      logic [15:0] low_accum_reg;
   } soag_gprs_t;
   typedef struct packed {
      soag_ref_t   ref_kind;
      soag_mode_t  mode;
      logic        use_bp;
      logic        use_di;
      logic        disp_wide;
      logic [15:0] disp;
      logic        ovr_valid;
      soag_seg_t   ovr_seg;
      logic [15:0] fetch_ofs;
      logic [15:0] stack_ofs;
   } soag_req_t;
   typedef struct packed {
      logic [19:0] phys_addr;
      logic [15:0] eff_addr;
      soag_seg_t   seg_sel;
      logic [15:0] seg_val;
   } soag_resp_t;
endpackage : soag_pkg

// file: testbench/soag_tb.sv
/*
 Self-checking bench for the segmented operand address generator.
 Assumes soag_pkg is compiled first and that the design's own assertions run alongside.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); fail_count++; end end
module tb;
   import soag_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   soag_segs_t  segs;
   soag_gprs_t  gprs;
   logic        req_valid = 1'b0;
   soag_req_t   req = '0;
   logic        resp_valid;
   soag_resp_t  resp;
   logic [15:0] op_a = 16'h0000;
   logic [15:0] op_b = 16'h0000;
   logic        op_byte = 1'b0;
   logic [16:0] op_signed_sum;
   logic [7:0]  bcd_packed;
   logic [3:0]  bcd_hi_digit = 4'h0;
   logic [3:0]  bcd_lo_digit = 4'h0;
   logic [31:0] dword_value;
   logic [31:0] far_pointer;
   logic [16:0] str_len = 17'h00000;
   logic        str_len_ok;
   int          fail_count = 0;
   int          total_checks = 0;
   int          cycles = 0;

   soag_addr_gen dut (.clk(clk), .rst(rst), .segs(segs), .gprs(gprs), .req_valid(req_valid),
      .req(req), .resp_valid(resp_valid), .resp(resp), .op_a(op_a), .op_b(op_b),
      .op_byte(op_byte), .op_signed_sum(op_signed_sum), .bcd_packed(bcd_packed),
      .bcd_hi_digit(bcd_hi_digit), .bcd_lo_digit(bcd_lo_digit), .dword_value(dword_value),
      .far_pointer(far_pointer), .str_len(str_len), .str_len_ok(str_len_ok));

   always #10 clk = ~clk;

   // The ceiling sits far above the 45 or so cycles the tests need.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         conclude();
      end
   end

   function automatic soag_req_t mk(soag_ref_t k, soag_mode_t m, logic bp, logic di,
                                    logic w, logic [15:0] d, logic ov, soag_seg_t os);
      soag_req_t r;
      r = '0;
      r.ref_kind = k;
      r.mode = m;
      r.use_bp = bp;
      r.use_di = di;
      r.disp_wide = w;
      r.disp = d;
      r.ovr_valid = ov;
      r.ovr_seg = os;
      r.fetch_ofs = 16'h0020;
      r.stack_ofs = 16'hFFFE;
      return r;
   endfunction : mk

   function automatic logic [15:0] seg_of(soag_seg_t s);
      case (s)
         SOAG_SEG_DATA:  return segs.data_segment_reg;
         SOAG_SEG_CODE:  return segs.code_segment_reg;
         SOAG_SEG_STACK: return segs.stack_segment_reg;
         default:        return segs.extra_segment_reg;
      endcase
   endfunction : seg_of

   // One request, answer judged one cycle later; the physical sum keeps 20 bits only.
   task automatic issue(input soag_req_t r, input soag_seg_t s, input logic [15:0] e);
      logic [15:0] sv;
      logic [19:0] pa;
      sv = seg_of(s);
      pa = {sv, 4'h0} + {4'h0, e};
      @(posedge clk);
      req_valid <= 1'b1;
      req <= r;
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      `CHK(resp_valid, 1'b1)
      `CHK(resp.seg_sel, s)
      `CHK(resp.eff_addr, e)
      `CHK(resp.seg_val, sv)
      `CHK(resp.phys_addr, pa)
      `CHK(far_pointer, {sv, e})
   endtask : issue

   task automatic test_segments();
      issue(mk(SOAG_REF_DATA, SOAG_AM_DIRECT, 0, 0, 1, 16'h0004, 0, SOAG_SEG_DATA),
            SOAG_SEG_DATA, 16'h0004);
      issue(mk(SOAG_REF_FETCH, SOAG_AM_DIRECT, 0, 0, 1, 16'h0000, 1, SOAG_SEG_EXTRA),
            SOAG_SEG_CODE, 16'h0020);
      issue(mk(SOAG_REF_STACK, SOAG_AM_DIRECT, 0, 0, 1, 16'h0000, 0, SOAG_SEG_DATA),
            SOAG_SEG_STACK, 16'hFFFE);
      issue(mk(SOAG_REF_STR_DST, SOAG_AM_REG_IND, 0, 1, 0, 16'h0001, 0, SOAG_SEG_DATA),
            SOAG_SEG_EXTRA, 16'h0004);
      issue(mk(SOAG_REF_DATA, SOAG_AM_BASED, 1, 0, 1, 16'h0000, 1, SOAG_SEG_EXTRA),
            SOAG_SEG_EXTRA, 16'h0200);
      issue(mk(SOAG_REF_STR_SRC, SOAG_AM_REG_IND, 0, 0, 0, 16'h0000, 1, SOAG_SEG_STACK),
            SOAG_SEG_STACK, 16'h0030);
      @(posedge clk);
      #1;
      `CHK(resp_valid, 1'b0)
      $display("test_segments done");
   endtask : test_segments

   task automatic test_offsets();
      issue(mk(SOAG_REF_DATA, SOAG_AM_DIRECT, 0, 0, 0, 16'h0080, 0, SOAG_SEG_DATA),
            SOAG_SEG_DATA, 16'hFF80);
      issue(mk(SOAG_REF_DATA, SOAG_AM_REG_IND, 1, 0, 0, 16'h0003, 0, SOAG_SEG_DATA),
            SOAG_SEG_STACK, 16'h0200);
      issue(mk(SOAG_REF_DATA, SOAG_AM_BASED, 0, 0, 1, 16'hF000, 0, SOAG_SEG_DATA),
            SOAG_SEG_DATA, 16'h0000);
      issue(mk(SOAG_REF_DATA, SOAG_AM_INDEXED, 0, 1, 0, 16'h00FE, 0, SOAG_SEG_DATA),
            SOAG_SEG_DATA, 16'h0002);
      issue(mk(SOAG_REF_DATA, SOAG_AM_BASE_IDX, 1, 0, 0, 16'h0000, 0, SOAG_SEG_DATA),
            SOAG_SEG_STACK, 16'h0230);
      issue(mk(SOAG_REF_DATA, SOAG_AM_BASE_IDX_DISP, 0, 1, 0, 16'h0010, 0, SOAG_SEG_DATA),
            SOAG_SEG_DATA, 16'h1014);
      issue(mk(SOAG_REF_DATA, SOAG_AM_REG_IND, 0, 0, 0, 16'h0003, 0, SOAG_SEG_DATA),
            SOAG_SEG_STACK, 16'h0200);
      issue(mk(SOAG_REF_DATA, SOAG_AM_INDEXED, 1, 0, 1, 16'h0010, 0, SOAG_SEG_DATA),
            SOAG_SEG_DATA, 16'h0040);
      issue(mk(SOAG_REF_STR_DST, SOAG_AM_REG_IND, 0, 0, 0, 16'h0000, 0, SOAG_SEG_DATA),
            SOAG_SEG_DATA, 16'h0030);
      $display("test_offsets done");
   endtask : test_offsets

   task automatic fmt(input logic [15:0] a, input logic [15:0] b, input logic byt,
                      input logic [3:0] hi, input logic [3:0] lo, input logic [16:0] len,
                      input logic [16:0] sum, input logic ok);
      @(posedge clk);
      op_a <= a;
      op_b <= b;
      op_byte <= byt;
      bcd_hi_digit <= hi;
      bcd_lo_digit <= lo;
      str_len <= len;
      @(posedge clk);
      #1;
      `CHK(op_signed_sum, sum)
      `CHK(bcd_packed, {hi, lo})
      `CHK(dword_value, {gprs.high_accum_reg, gprs.low_accum_reg})
      `CHK(str_len_ok, ok)
   endtask : fmt

   task automatic test_formats();
      fmt(16'h0080, 16'h00FF, 1'b1, 4'h9, 4'h3, 17'h00000, 17'h1FF7F, 1'b0);
      fmt(16'h8000, 16'hFFFF, 1'b0, 4'h0, 4'h9, 17'h00001, 17'h17FFF, 1'b1);
      @(posedge clk);
      gprs.high_accum_reg <= 16'h8001;
      fmt(16'h7FFF, 16'h0001, 1'b0, 4'h5, 4'h0, 17'h10000, 17'h08000, 1'b1);
      fmt(16'h0000, 16'h0000, 1'b0, 4'h1, 4'h2, 17'h10001, 17'h00000, 1'b0);
      $display("test_formats done");
   endtask : test_formats

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude

   initial begin
      segs <= {16'h1234, 16'hFFFF, 16'h2000, 16'h3000};
      gprs <= {16'h1000, 16'h0200, 16'h0030, 16'h0004, 16'hABCD, 16'h1234};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHK(resp, soag_resp_t'(0))
      test_segments();
      test_offsets();
      test_formats();
      conclude();
   end
endmodule : tb
`default_nettype wire
